//--- rtl/apt_pkg.sv
// constants and types for the absolute position transfer block
package apt_pkg;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned T_SON_MS     = 100;
  localparam int unsigned T_RDY_MS     = 20;
  localparam int unsigned T_EMGPWR_MS  = 200;
  localparam int unsigned T_CRSET_MS   = 20;
  localparam int unsigned MS_CYC       = CLK_MHZ * 1000;
  localparam int unsigned SON_CYC      = T_SON_MS * MS_CYC;
  localparam int unsigned RDY_CYC      = T_RDY_MS * MS_CYC;
  localparam int unsigned EMGPWR_CYC   = T_EMGPWR_MS * MS_CYC;
  localparam int unsigned CRSET_CYC    = T_CRSET_MS * MS_CYC;
  localparam int unsigned HOME_LIMIT   = 100000;
  localparam logic [7:0]  CMD_READ     = 8'h02;
  localparam logic [7:0]  DNUM_ABSPOS  = 8'h91;
  localparam logic [7:0]  ERR_COMM     = 8'h01;
  localparam logic [3:0]  ABS_SEL_DIG  = 4'h1;
  localparam logic [31:0] POS_RST      = 32'h0000_0000;
  localparam logic [16:0] HCNT_RST     = 17'h0_0000;

  typedef enum logic [3:0] {
    ST_OFF  = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_BASE = 4'b0100,
    ST_RDY  = 4'b1000
  } apt_state_e;
endpackage

//--- rtl/apt_abs_position.sv
// servo drive absolute position transfer, power sequencing and homing
// Summary of operation
// (RULE1) controller addresses read to our station
// (RULE2) command 02 data 91 returns position
// (RULE3) reply is 32-bit position, hex characters
// (RULE4) absolute mode needs parameter digit, power cycle
// (RULE5) first power-up raises erase alarm
// (RULE6) controller sets home after setup changes
// (RULE7) controller reads position at each servo-on
// (RULE8) reply loads internal position command register
// (RULE9) base circuit on 100 ms after servo-on
// (RULE10) ready follows base circuit by 20 ms
// (RULE11) controller pulses only after ready, position
// (RULE12) communication fault answers with error code
// (RULE13) controller retries, then handles error
// (RULE14) controller drops servo-on on alarm
// (RULE15) power-up forced stop: 200 ms, 20 ms
// (RULE16) forced stop in servo-on: 100 ms, 20 ms
// (RULE17) dog homing edge clears droop, stores home
// (RULE18) homing outside in-position raises warning
// (RULE19) data-set homing after 20 ms hold
// (RULE20) data-set homing allowed with servo off
// (RULE21) at most 100,000 home stores
// (RULE22) home-set clears counter, writes backup memory
`timescale 1ns/10ps
module apt_abs_position
  import apt_pkg::*;
#(
  parameter int unsigned SON_CYCLES    = SON_CYC,
  parameter int unsigned RDY_CYCLES    = RDY_CYC,
  parameter int unsigned EMGPWR_CYCLES = EMGPWR_CYC,
  parameter int unsigned CRSET_CYCLES  = CRSET_CYC
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        servoOnInput,
  input  wire logic        forcedStopInput,
  input  wire logic        homeSetInput,
  input  wire logic        inPositionOutput,
  input  wire logic        zeroPulse,
  input  wire logic        dogMode,
  input  wire logic [3:0]  paramAbsDigit,
  input  wire logic        encoderFresh,
  input  wire logic [31:0] currentPos,
  input  wire logic        cmdValid,
  input  wire logic        cmdStationMatch,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [7:0]  cmdDataNum,
  input  wire logic        cmdCommFault,
  input  wire logic        faultClear,
  output logic             baseOn,
  output logic             ready,
  output logic             faultOutput,
  output logic             homeWarn,
  output logic             absActive,
  output logic             replyValid,
  output logic             replyErr,
  output logic [7:0]       replyErrCode,
  output logic [63:0]      replyHex,
  output logic [31:0]      posCmd,
  output logic             droopClear,
  output logic             suddenStop,
  output logic             homeStore,
  output logic [31:0]      homePos,
  output logic             homeLimitHit
);

  // ****************************************
  // hex character conversion
  // ****************************************
  function automatic logic [63:0] toHex(input logic [31:0] v);
    logic [63:0] r;
    logic [3:0]  n;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      n = v[i*4 +: 4];
      r[i*8 +: 8] = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
    return r;
  endfunction

  // ****************************************
  // power-up capture and sequencing
  // ****************************************
  apt_state_e  state_q, state_d;
  logic [27:0] tmr_q, tmr_d;
  logic        init_q, init_d;
  logic        absAct_q, absAct_d;
  logic        fault_q, fault_d;
  logic        emgAtPwr_q, emgAtPwr_d;
  logic        fs_q, fs_d;
  logic        baseOn_q, baseOn_d;
  logic        ready_q, ready_d;

  always_comb begin
    state_d    = state_q;
    tmr_d      = tmr_q;
    init_d     = 1'b1;
    absAct_d   = absAct_q;
    fault_d    = fault_q;
    emgAtPwr_d = emgAtPwr_q;
    fs_d       = forcedStopInput;
    if (!init_q) begin
      // (RULE4) digit latched only at power-up
      absAct_d   = (paramAbsDigit == ABS_SEL_DIG);
      // (RULE5) erase alarm on fresh encoder
      fault_d    = (paramAbsDigit == ABS_SEL_DIG) && encoderFresh;
      emgAtPwr_d = forcedStopInput;
    end else if (faultClear && !encoderFresh) begin
      fault_d = 1'b0;
    end
    if (!servoOnInput || forcedStopInput || fault_q) begin
      state_d = ST_OFF;
      tmr_d   = '0;
      if (fs_q && !forcedStopInput) emgAtPwr_d = emgAtPwr_q;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_d = ST_WAIT;
          tmr_d   = '0;
        end
        ST_WAIT: begin
          // (RULE9) (RULE15) (RULE16) base delay
          if (tmr_q + 28'd1 >= (emgAtPwr_q ? 28'(EMGPWR_CYCLES) : 28'(SON_CYCLES))) begin
            state_d    = ST_BASE;
            tmr_d      = '0;
            emgAtPwr_d = 1'b0;
          end else begin
            tmr_d = tmr_q + 28'd1;
          end
        end
        ST_BASE: begin
          // (RULE10) ready after base
          if (tmr_q + 28'd1 >= 28'(RDY_CYCLES)) begin
            state_d = ST_RDY;
          end else begin
            tmr_d = tmr_q + 28'd1;
          end
        end
        ST_RDY: state_d = ST_RDY;
      endcase
    end
    // outputs registered from the next state, so no decode sits on a pin
    baseOn_d = (state_d == ST_BASE) || (state_d == ST_RDY);
    ready_d  = (state_d == ST_RDY);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_OFF;
      tmr_q      <= '0;
      init_q     <= 1'b0;
      absAct_q   <= 1'b0;
      fault_q    <= 1'b0;
      emgAtPwr_q <= 1'b0;
      fs_q       <= 1'b0;
      baseOn_q   <= 1'b0;
      ready_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      tmr_q      <= tmr_d;
      init_q     <= init_d;
      absAct_q   <= absAct_d;
      fault_q    <= fault_d;
      emgAtPwr_q <= emgAtPwr_d;
      fs_q       <= fs_d;
      baseOn_q   <= baseOn_d;
      ready_q    <= ready_d;
    end
  end

  // ****************************************
  // serial read and homing
  // ****************************************
  logic        rv_q, rv_d, re_q, re_d, dc_q, dc_d, hs_q, hs_d, hw_q, hw_d;
  logic        cr_q, lim_q, lim_d, done_q, done_d;
  logic [7:0]  ec_q, ec_d;
  logic [63:0] hex_q, hex_d;
  logic [31:0] pc_q, pc_d, hp_q, hp_d;
  logic [27:0] hold_q, hold_d;
  logic [16:0] hcnt_q, hcnt_d;
  logic        req, homeTry, servoOn;

  assign servoOn = (state_q == ST_RDY) || (state_q == ST_BASE);

  always_comb begin
    rv_d   = 1'b0;
    re_d   = 1'b0;
    ec_d   = ec_q;
    hex_d  = hex_q;
    pc_d   = pc_q;
    dc_d   = 1'b0;
    hs_d   = 1'b0;
    hw_d   = hw_q;
    hp_d   = hp_q;
    hold_d = homeSetInput ? hold_q : '0;
    hcnt_d = hcnt_q;
    lim_d  = (hcnt_q >= 17'(HOME_LIMIT));
    done_d = homeSetInput ? done_q : 1'b0;
    req    = cmdValid && cmdStationMatch && cmdCode == CMD_READ && cmdDataNum == DNUM_ABSPOS;
    if (req && absAct_q) begin
      if (cmdCommFault) begin
        // (RULE12) error code reply
        re_d = 1'b1;
        ec_d = ERR_COMM;
      end else begin
        // (RULE2) (RULE3) hex position reply
        rv_d  = 1'b1;
        hex_d = toHex(currentPos);
        // (RULE8) same value to command reg
        pc_d  = currentPos;
      end
    end
    homeTry = 1'b0;
    if (dogMode) begin
      // (RULE17) rising edge at zero pulse
      homeTry = homeSetInput && !cr_q && zeroPulse;
    end else if (homeSetInput && !done_q) begin
      // (RULE19) (RULE20) hold time, servo on or off
      if (hold_q + 28'd1 >= 28'(CRSET_CYCLES)) begin
        homeTry = 1'b1;
        done_d  = 1'b1;
      end else begin
        hold_d = hold_q + 28'd1;
      end
    end
    if (homeSetInput && !cr_q && servoOn && !inPositionOutput) begin
      // (RULE18) warning
      hw_d = 1'b1;
    end else if (homeTry && (!servoOn || inPositionOutput) && !lim_q) begin
      // (RULE21) (RULE22) store, clear counter
      hw_d   = 1'b0;
      hs_d   = 1'b1;
      dc_d   = 1'b1;
      hp_d   = currentPos;
      pc_d   = POS_RST;
      hcnt_d = hcnt_q + 17'd1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rv_q   <= 1'b0;
      re_q   <= 1'b0;
      ec_q   <= '0;
      hex_q  <= '0;
      pc_q   <= POS_RST;
      dc_q   <= 1'b0;
      hs_q   <= 1'b0;
      hw_q   <= 1'b0;
      hp_q   <= POS_RST;
      hold_q <= '0;
      hcnt_q <= HCNT_RST;
      cr_q   <= 1'b0;
      lim_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rv_q   <= rv_d;
      re_q   <= re_d;
      ec_q   <= ec_d;
      hex_q  <= hex_d;
      pc_q   <= pc_d;
      dc_q   <= dc_d;
      hs_q   <= hs_d;
      hw_q   <= hw_d;
      hp_q   <= hp_d;
      hold_q <= hold_d;
      hcnt_q <= hcnt_d;
      cr_q   <= homeSetInput;
      lim_q  <= lim_d;
      done_q <= done_d;
    end
  end

  assign baseOn       = baseOn_q;
  assign ready        = ready_q;
  assign faultOutput  = fault_q;
  assign homeWarn     = hw_q;
  assign absActive    = absAct_q;
  assign replyValid   = rv_q;
  assign replyErr     = re_q;
  assign replyErrCode = ec_q;
  assign replyHex     = hex_q;
  assign posCmd       = pc_q;
  assign droopClear   = dc_q;
  assign suddenStop   = dc_q;
  assign homeStore    = hs_q;
  assign homePos      = hp_q;
  assign homeLimitHit = lim_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_READY_AFTER_BASE: assert property (ready |-> baseOn) // (RULE10)
    else $error("ready without base circuit");
  AST_READ_REPLY: assert property (req && absAct_q && !cmdCommFault |=> replyValid) // (RULE2)
    else $error("missing position reply");
  AST_POS_LOAD: assert property (replyValid |-> posCmd == $past(currentPos)) // (RULE8)
    else $error("command register not loaded");
  AST_ERR_REPLY: assert property (req && absAct_q && cmdCommFault |=> replyErr) // (RULE12)
    else $error("missing error reply");
  AST_BASE_DELAY: assert property ($rose(baseOn) |-> $past(state_q) == ST_WAIT) // (RULE9)
    else $error("base without wait");
  AST_EMG_DROPS: assert property (forcedStopInput |=> !baseOn) // (RULE16)
    else $error("base on in forced stop");
  AST_HOME_WARN: assert property (homeStore |-> !homeWarn) // (RULE18)
    else $error("warning stays after homing");
  AST_HOME_CLEAR: assert property (homeStore |-> droopClear && posCmd == 32'h0000_0000) // (RULE22)
    else $error("home store without counter clear");
  AST_LIMIT: assert property (lim_q |=> !homeStore) // (RULE21)
    else $error("home store past limit");

  COV_READY: cover property ($rose(ready));
  COV_READ: cover property (replyValid);
  COV_HOME: cover property (homeStore);
  COV_WARN: cover property ($rose(homeWarn));

endmodule

//--- tb/apt_ctrl_model.sv
// positioning controller model: position read on ready, retries
`timescale 1ns/10ps
module apt_ctrl_model
  import apt_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       ready,
  input  wire logic       replyValid,
  input  wire logic       replyErr,
  input  wire logic       reqGo,
  input  wire logic       reqStation,
  input  wire logic [7:0] reqCode,
  output logic            cmdValid,
  output logic            cmdStationMatch,
  output logic [7:0]      cmdCode,
  output logic [7:0]      cmdDataNum,
  output logic            posKnown
);
  logic readyQ;
  int   tries;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {readyQ, cmdValid, cmdStationMatch, posKnown} <= 4'h0;
      {cmdCode, cmdDataNum} <= 16'h0000;
      tries <= 0;
    end else begin
      readyQ <= ready;
      // idle fields keep changing so a stale value never looks valid
      {cmdValid, cmdStationMatch, cmdCode, cmdDataNum} <= {1'b0, ~cmdStationMatch, ~cmdCode, ~cmdDataNum};
      // read own station at each ready rise
      if (ready && !readyQ) begin
        {cmdValid, cmdStationMatch, cmdCode, cmdDataNum} <= {2'b11, CMD_READ, DNUM_ABSPOS};
        tries <= 0;
      end else if (reqGo || (replyErr && tries < 3)) begin
        // a few retries, then the error stands
        {cmdValid, cmdStationMatch, cmdCode, cmdDataNum} <= {1'b1, reqStation, reqCode, DNUM_ABSPOS};
        tries <= reqGo ? 0 : tries + 1;
      end
      // pulses allowed only with ready and position
      posKnown <= ready && (posKnown || replyValid);
    end
  end
endmodule

//--- tb/apt_abs_position_tb.sv
// bench for the absolute position transfer block
`timescale 1ns/10ps
module apt_abs_position_tb;
  import apt_pkg::*;
  logic        mclk = 0, resetn = 0, servo_on_input = 0, stop = 0, hset = 0, inPos = 0;
  logic        zp = 0, dog = 0, fresh = 0, flt = 0, fclr = 0, go = 0, sta = 1;
  logic [3:0]  dig = 4'h1;
  logic [7:0]  code = 8'h02;
  logic [31:0] pos = 32'h0001_86A0;
  logic        bOn, rdy, fo, hw, aa, rv, re, dc, ss, hs, hl, cv, cs, pk;
  logic [7:0]  ec, cc, cd;
  logic [63:0] hx, hexExp;
  logic [31:0] pc, hp;
  int          n_errors = 0, check_count = 0, cyc = 0, n;

  always #2 mclk = ~mclk;
  apt_abs_position #(.SON_CYCLES(10), .RDY_CYCLES(5), .EMGPWR_CYCLES(20), .CRSET_CYCLES(5)) dut (
    .mclk(mclk), .resetn(resetn), .servoOnInput(servo_on_input), .forcedStopInput(stop),
    .homeSetInput(hset), .inPositionOutput(inPos), .zeroPulse(zp), .dogMode(dog),
    .paramAbsDigit(dig), .encoderFresh(fresh), .currentPos(pos), .cmdValid(cv),
    .cmdStationMatch(cs), .cmdCode(cc), .cmdDataNum(cd), .cmdCommFault(flt),
    .faultClear(fclr), .baseOn(bOn), .ready(rdy), .faultOutput(fo), .homeWarn(hw),
    .absActive(aa), .replyValid(rv), .replyErr(re), .replyErrCode(ec), .replyHex(hx),
    .posCmd(pc), .droopClear(dc), .suddenStop(ss), .homeStore(hs), .homePos(hp),
    .homeLimitHit(hl));
  apt_ctrl_model ctrl (
    .mclk(mclk), .resetn(resetn), .ready(rdy), .replyValid(rv), .replyErr(re),
    .reqGo(go), .reqStation(sta), .reqCode(code), .cmdValid(cv),
    .cmdStationMatch(cs), .cmdCode(cc), .cmdDataNum(cd), .posKnown(pk));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkR(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // k is 999 when the signal never rose within lim cycles
  task automatic waitBit(input int sel, input int lim, output int k);
    logic s;
    k = 0;
    do begin
      // sampled at the falling edge, where outputs have settled
      @(negedge mclk);
      s = sel == 0 ? bOn : sel == 1 ? rdy : sel == 2 ? rv : sel == 3 ? re : hs;
      k++;
    end while (s !== 1'b1 && k < lim);
    if (s !== 1'b1) k = 999;
  endtask
  task automatic doReset(input logic [3:0] d, input logic f, input logic st);
    @(posedge mclk);
    {resetn, dig, fresh, stop} <= {1'b0, d, f, st};
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic ask(input logic s, input logic [7:0] c);
    @(posedge mclk);
    {go, sta, code} <= {1'b1, s, c};
    @(posedge mclk);
    go <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    for (int i = 0; i < 8; i++)
      hexExp[8*i+:8] = pos[4*i+:4] < 10 ? 8'h30 + pos[4*i+:4] : 8'h37 + pos[4*i+:4];
    doReset(4'h1, 1'b0, 1'b0);
    chk(aa, 1'b1);
    chk(pk, 1'b0);
    @(posedge mclk);
    servo_on_input <= 1'b1;
    waitBit(0, 40, n);
    chkR(n, 10, 13);
    waitBit(1, 20, n);
    chkR(n, 4, 6);
    waitBit(2, 20, n);
    chk(hx, hexExp);
    chk(pc, pos);
    @(negedge mclk);
    chk(pk, 1'b1);
    // wrong command code, then wrong station: both unanswered
    ask(1'b1, 8'h70);
    waitBit(2, 4, n);
    chkR(n, 999, 999);
    ask(1'b0, CMD_READ);
    waitBit(2, 4, n);
    chkR(n, 999, 999);
    @(posedge mclk);
    flt <= 1'b1;
    ask(1'b1, CMD_READ);
    waitBit(3, 4, n);
    chkR(n, 1, 4);
    chk(ec, ERR_COMM);
    @(posedge mclk);
    flt <= 1'b0;
    // the model resends by itself after the error reply
    waitBit(2, 6, n);
    chkR(n, 1, 6);
    @(posedge mclk);
    stop <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({bOn, rdy}, 2'b00);
    chk(pk, 1'b0);
    @(posedge mclk);
    stop <= 1'b0;
    waitBit(0, 40, n);
    chkR(n, 10, 13);
    waitBit(1, 20, n);
    chkR(n, 4, 6);
    // home-set while on but not in position
    @(posedge mclk);
    inPos <= 1'b0;
    hset <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(hw, 1'b1);
    @(posedge mclk);
    {hset, inPos, dog, zp} <= 4'b0111;
    @(posedge mclk);
    hset <= 1'b1;
    waitBit(4, 3, n);
    chk({dc, ss, hp}, {2'b11, pos});
    chk(pc, 32'h0000_0000);
    chk(hw, 1'b0);
    @(posedge mclk);
    {servo_on_input, dog, zp, hset, pos} <= {4'b0000, 32'h8000_0001};
    @(posedge mclk);
    hset <= 1'b1;
    waitBit(4, 12, n);
    chkR(n, 4, 8);
    chk(hp, 32'h8000_0001);
    waitBit(4, 10, n);
    chkR(n, 999, 999);
    @(posedge mclk);
    {hset, servo_on_input} <= 2'b01;
    doReset(4'h1, 1'b0, 1'b1);
    repeat (5) @(negedge mclk);
    chk(bOn, 1'b0);
    @(posedge mclk);
    stop <= 1'b0;
    waitBit(0, 60, n);
    chkR(n, 20, 23);
    waitBit(1, 20, n);
    chkR(n, 4, 6);
    // servo-on stays off through the alarm
    @(posedge mclk);
    servo_on_input <= 1'b0;
    doReset(4'h1, 1'b1, 1'b0);
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(fo, 1'b1);
    // clear honoured once the encoder is no longer fresh
    @(posedge mclk);
    {fresh, fclr} <= 2'b01;
    @(posedge mclk);
    fclr <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(fo, 1'b0);
    doReset(4'h1, 1'b0, 1'b0);
    chk(fo, 1'b0);
    // home is set again once the erase alarm is gone
    @(posedge mclk);
    hset <= 1'b1;
    waitBit(4, 12, n);
    chkR(n, 4, 8);
    chk(hp, pos);
    @(posedge mclk);
    hset <= 1'b0;
    doReset(4'h0, 1'b0, 1'b0);
    chk(aa, 1'b0);
    ask(1'b1, CMD_READ);
    waitBit(2, 4, n);
    chkR(n, 999, 999);
    chk(hl, 1'b0);
    report_and_stop();
  end
endmodule
